// *** rtl/scf_pkg.sv ***
// Shared constants and types of the serial format and transmit buffer block.
// Assumes a single 40 MHz clock and an AXI4-Lite master on the register side.
`default_nettype none

package scf_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam int          AXI_AW    = 8;
  localparam logic [7:0]  ADDR_HOLD = 8'h00;
  localparam logic [7:0]  ADDR_FMT  = 8'h04;
  localparam logic [7:0]  ADDR_CTRL = 8'h08;
  localparam logic [7:0]  ADDR_STAT = 8'h0c;
  localparam logic [7:0]  ADDR_RXD  = 8'h10;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  HOLD_RST  = 8'hff;
  localparam logic [7:0]  FMT_RST   = 8'h00;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [7:0]  RXD_RST   = 8'h00;

  // ==========================================================================
  // Format register fields
  localparam int FMT_SYNC  = 7;
  localparam int FMT_CHR7  = 6;
  localparam int FMT_PE    = 5;
  localparam int FMT_ODD   = 4;
  localparam int FMT_STOP2 = 3;
  localparam int FMT_MP    = 2;
  localparam int FMT_CKS   = 0;

  // Control register fields
  localparam int CTRL_TXEN   = 0;
  localparam int CTRL_RXEN   = 1;
  localparam int CTRL_MPBT   = 2;
  localparam int CTRL_DIV_LO = 8;

  // Status register fields
  localparam int ST_EMPTY = 7;
  localparam int ST_FULL  = 6;
  localparam int ST_OVR   = 5;
  localparam int ST_FRM   = 4;
  localparam int ST_PAR   = 3;
  localparam int ST_TXEND = 2;
  localparam int ST_MPB   = 1;

  // ==========================================================================
  // Timing counts
  localparam logic [3:0] OS_LAST   = 4'hf;
  localparam logic [3:0] OS_HALF   = 4'h8;
  localparam logic [3:0] OS_SAMPLE = 4'h7;
  localparam logic [5:0] PRE4_MASK  = 6'h03;
  localparam logic [5:0] PRE16_MASK = 6'h0f;
  localparam logic [5:0] PRE64_MASK = 6'h3f;

  // ==========================================================================
  // Bus answers and states
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} scf_tx_state_type;
  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_BUSY = 1'b1} scf_rx_state_type;

endpackage : scf_pkg

`default_nettype wire

// *** rtl/scf_tx_if.sv ***
// Link between the register side and the transmit shifter.
// Assumes both ends run on the same clock.
`default_nettype none

interface scf_tx_if;
  logic       os_tick;
  logic       clr;
  logic       load;
  logic [7:0] data;
  logic [7:0] fmt;
  logic       mp_bit;
  logic       idle;
  logic       txd;
  logic       sck;

  modport ctl (output os_tick, clr, load, data, fmt, mp_bit, input idle, txd, sck);
  modport shf (input os_tick, clr, load, data, fmt, mp_bit, output idle, txd, sck);
endinterface : scf_tx_if

`default_nettype wire

// *** rtl/scf_tx_shifter.sv ***
// Transmit shifter: frames one character and shifts it out.
// Assumes os_tick is a one-cycle enable at sixteen times the bit rate.
`default_nettype none

module scf_tx_shifter import scf_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to the buffer side
  scf_tx_if.shf    link
);

  // ==========================================================================
  // State
  scf_tx_state_type state_q, state_d;
  logic [11:0] frame_q, frame_d, frame_n;
  logic [3:0]  len_q, len_d, len_n;
  logic [3:0]  bit_q, bit_d;
  logic [3:0]  os_q, os_d;
  logic        sync_q, sync_d;
  logic        txd_q, txd_d;
  logic        sck_q, sck_d;
  logic [7:0]  dv;
  logic [3:0]  nd;
  logic        ext;
  logic        has_ext;

  assign link.idle = (state_q == TX_IDLE);
  assign link.txd  = txd_q;
  assign link.sck  = sck_q;

  // ==========================================================================
  // Frame assembly
  always_comb begin
    dv      = link.fmt[FMT_CHR7] ? {1'b0, link.data[6:0]} : link.data;
    nd      = link.fmt[FMT_CHR7] ? 4'd7 : 4'd8;
    has_ext = link.fmt[FMT_MP] | link.fmt[FMT_PE];
    ext     = link.fmt[FMT_MP] ? link.mp_bit : (^dv ^ link.fmt[FMT_ODD]);
    frame_n = 12'hfff;
    frame_n[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nd)) begin
        frame_n[i + 1] = dv[i];
      end
    end
    if (has_ext) begin
      frame_n[nd + 4'd1] = ext;
    end
    len_n = nd + {3'b000, has_ext} + 4'd2 + {3'b000, link.fmt[FMT_STOP2]};
    if (link.fmt[FMT_SYNC]) begin
      frame_n = {4'hf, link.data};
      len_n   = 4'd8;
    end
  end

  // ==========================================================================
  // Shift sequencing
  always_comb begin
    state_d = state_q;
    frame_d = frame_q;
    len_d   = len_q;
    bit_d   = bit_q;
    os_d    = os_q;
    sync_d  = sync_q;
    case (state_q)
      TX_IDLE: begin
        if (link.load) begin
          frame_d = frame_n;
          len_d   = len_n;
          sync_d  = link.fmt[FMT_SYNC];
          bit_d   = 4'd0;
          os_d    = 4'd0;
          state_d = TX_SEND;
        end
      end
      TX_SEND: begin
        if (link.os_tick) begin
          os_d = os_q + 4'd1;
          if (os_q == OS_LAST) begin
            frame_d = {1'b1, frame_q[11:1]};
            bit_d   = bit_q + 4'd1;
            if (bit_q == len_q - 4'd1) begin
              state_d = TX_IDLE;
            end
          end
        end
      end
      default: state_d = TX_IDLE;
    endcase
    if (link.clr) begin
      state_d = TX_IDLE;
    end
    // Line idles high; clock low in first half of a synchronous bit
    txd_d = (state_d == TX_SEND) ? frame_d[0] : 1'b1;
    sck_d = !((state_d == TX_SEND) && sync_d && (os_d < OS_HALF));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= TX_IDLE;
      frame_q <= 12'hfff;
      len_q   <= 4'h0;
      bit_q   <= 4'h0;
      os_q    <= 4'h0;
      sync_q  <= 1'b0;
      txd_q   <= 1'b1;
      sck_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      frame_q <= frame_d;
      len_q   <= len_d;
      bit_q   <= bit_d;
      os_q    <= os_d;
      sync_q  <= sync_d;
      txd_q   <= txd_d;
      sck_q   <= sck_d;
    end
  end

endmodule : scf_tx_shifter

`default_nettype wire

// *** rtl/scf_top.sv ***
// Serial channel: AXI4-Lite registers, baud prescaler, receiver, transmit buffer.
// Assumes one 40 MHz clock; standby comes from logic on the same clock.
//
// Contract
// - Empty shifter loads holding byte, starts sending
// - Holding buffer accepts writes during transmission
// - Holding buffer read/write, all ones on reset/standby
// - Format register always readable and writable
// - Format register zero on reset and standby
// - Format bit 7 selects async or synchronous
// - Bit 6 selects 7/8 bits; sync always 8
// - Seven-bit characters drop the holding MSB
// - Bit 5 adds/checks parity, async only
// - Bit 4 picks even or odd parity
// - Bit 3 picks one or two stops
// - Receiver checks first stop bit only
// - Synchronous frames carry no stop bits
// - Bit 2 multiprocessor format overrides parity
// - Bits 1:0 pick prescaler 1/4/16/64
// - No load while buffer empty flag set
// - Characters go out least significant first
`default_nettype none

module scf_top import scf_pkg::*; #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address and data
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // Write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // Read
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [AXI_AW-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // Power control
  input  wire logic              standby,
  // Serial pins
  output logic                   txd,
  output logic                   sck,
  input  wire logic              rxd
);

  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
    $error("DIV_W must be 1 to 8");
  end

  // ==========================================================================
  // Declarations
  scf_tx_if tx ();

  logic             awready_q, awready_d, wready_q, wready_d;
  logic             bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]       bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]      rdata_q, rdata_d, wdata_q, wdata_d;
  logic [3:0]       wstrb_q, wstrb_d;
  logic [7:0]       awaddr_q, awaddr_d, wa, ra;
  logic             wr_fire, wr_hold, wr_fmt, wr_ctrl, wr_stat, wr_ok;

  logic [7:0]       hold_q, hold_d, fmt_q, fmt_d, rxbuf_q, rxbuf_d;
  logic [15:0]      ctrl_q, ctrl_d;
  logic             empty_q, empty_d, full_q, full_d, ovr_q, ovr_d;
  logic             frm_q, frm_d, par_q, par_d, mpb_q, mpb_d;
  logic [7:0]       stat;

  logic [5:0]       pre_q, pre_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic             pre_tick, os_tick;

  logic             rxd_m_q, rxd_s_q;
  scf_rx_state_type rx_state_q, rx_state_d;
  logic [3:0]       rx_os_q, rx_os_d, rx_idx_q, rx_idx_d, rnd, stop_idx;
  logic [9:0]       rx_bits_q, rx_bits_d;
  logic [7:0]       rdat;
  logic             rext, r_has_ext, rx_done;

  // ==========================================================================
  // Outputs
  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign txd     = tx.txd;
  assign sck     = tx.sck;

  // ==========================================================================
  // AXI4-Lite slave
  assign wa      = {awaddr_q[7:2], 2'b00};
  assign ra      = {araddr[7:2], 2'b00};
  // Address and data held until both arrive, then one write cycle
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  assign wr_hold = wr_fire && (wa == ADDR_HOLD) && wstrb_q[0];
  assign wr_fmt  = wr_fire && (wa == ADDR_FMT) && wstrb_q[0];
  assign wr_ctrl = wr_fire && (wa == ADDR_CTRL);
  assign wr_stat = wr_fire && (wa == ADDR_STAT) && wstrb_q[0];
  assign wr_ok   = (wa == ADDR_HOLD) || (wa == ADDR_FMT) || (wa == ADDR_CTRL)
                   || (wa == ADDR_STAT) || (wa == ADDR_RXD);

  always_comb begin
    awready_d = awready_q;
    wready_d  = wready_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (awvalid && awready_q) begin
      awready_d = 1'b0;
      awaddr_d  = awaddr;
    end
    if (wvalid && wready_q) begin
      wready_d = 1'b0;
      wdata_d  = wdata;
      wstrb_d  = wstrb;
    end
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d  = wr_ok ? RESP_OKAY : RESP_DECERR;
    end
    if (bvalid_q && bready) begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
    if (arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = RESP_OKAY;
      if (ra == ADDR_HOLD) begin
        rdata_d = {24'h0, hold_q};
      end else if (ra == ADDR_FMT) begin
        rdata_d = {24'h0, fmt_q};
      end else if (ra == ADDR_CTRL) begin
        rdata_d = {16'h0, ctrl_q};
      end else if (ra == ADDR_STAT) begin
        rdata_d = {24'h0, stat};
      end else if (ra == ADDR_RXD) begin
        rdata_d = {24'h0, rxbuf_q};
      end else begin
        rdata_d = 32'h0;
        rresp_d = RESP_DECERR;
      end
    end
    if (rvalid_q && rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ==========================================================================
  // Baud prescaler and divisor
  always_comb begin
    pre_d = pre_q + 6'd1;
    case (fmt_q[FMT_CKS +: 2])
      2'b00:   pre_tick = 1'b1;
      2'b01:   pre_tick = ((pre_q & PRE4_MASK) == PRE4_MASK);
      2'b10:   pre_tick = ((pre_q & PRE16_MASK) == PRE16_MASK);
      default: pre_tick = ((pre_q & PRE64_MASK) == PRE64_MASK);
    endcase
    os_tick = pre_tick && (div_q == '0);
    div_d   = div_q;
    if (pre_tick) begin
      div_d = (div_q == '0) ? ctrl_q[CTRL_DIV_LO +: DIV_W] : div_q - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 6'h00;
      div_q <= '0;
    end else begin
      pre_q <= pre_d;
      div_q <= div_d;
    end
  end

  // ==========================================================================
  // Receiver (asynchronous only)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end else begin
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
    end
  end

  always_comb begin
    rnd       = fmt_q[FMT_CHR7] ? 4'd7 : 4'd8;
    r_has_ext = fmt_q[FMT_MP] | fmt_q[FMT_PE];
    stop_idx  = rnd + {3'b000, r_has_ext} + 4'd1;
    rdat      = fmt_q[FMT_CHR7] ? {1'b0, rx_bits_q[6:0]} : rx_bits_q[7:0];
    rext      = rx_bits_q[rnd];
    rx_state_d = rx_state_q;
    rx_os_d    = rx_os_q;
    rx_idx_d   = rx_idx_q;
    rx_bits_d  = rx_bits_q;
    rx_done    = 1'b0;
    case (rx_state_q)
      RX_IDLE: begin
        if (ctrl_q[CTRL_RXEN] && !fmt_q[FMT_SYNC] && !rxd_s_q) begin
          rx_state_d = RX_BUSY;
          rx_os_d    = 4'd0;
          rx_idx_d   = 4'd0;
        end
      end
      RX_BUSY: begin
        if (os_tick) begin
          rx_os_d = rx_os_q + 4'd1;
          if (rx_os_q == OS_SAMPLE) begin
            rx_idx_d = rx_idx_q + 4'd1;
            if (rx_idx_q == 4'd0 && rxd_s_q) begin
              rx_state_d = RX_IDLE;
            end else if (rx_idx_q == stop_idx) begin
              // Back to idle mid stop bit; a low next bit is a new start
              rx_done    = 1'b1;
              rx_state_d = RX_IDLE;
            end else if (rx_idx_q != 4'd0) begin
              rx_bits_d[rx_idx_q - 4'd1] = rxd_s_q;
            end
          end
        end
      end
      default: rx_state_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      rx_state_q <= RX_IDLE;
      rx_os_q    <= 4'h0;
      rx_idx_q   <= 4'h0;
      rx_bits_q  <= 10'h000;
    end else begin
      rx_state_q <= rx_state_d;
      rx_os_q    <= rx_os_d;
      rx_idx_q   <= rx_idx_d;
      rx_bits_q  <= rx_bits_d;
    end
  end

  // ==========================================================================
  // Registers and transmit buffer
  assign tx.os_tick = os_tick;
  assign tx.clr     = standby;
  assign tx.data    = hold_q;
  assign tx.fmt     = fmt_q;
  assign tx.mp_bit  = ctrl_q[CTRL_MPBT];
  assign tx.load    = ctrl_q[CTRL_TXEN] && !empty_q && tx.idle;
  assign stat       = {empty_q, full_q, ovr_q, frm_q, par_q, tx.idle && empty_q, mpb_q, 1'b0};

  always_comb begin
    hold_d  = wr_hold ? wdata_q[7:0] : hold_q;
    fmt_d   = wr_fmt ? wdata_q[7:0] : fmt_q;
    ctrl_d  = ctrl_q;
    if (wr_ctrl && wstrb_q[0]) begin
      ctrl_d[2:0] = wdata_q[2:0];
    end
    if (wr_ctrl && wstrb_q[1]) begin
      ctrl_d[15:8] = wdata_q[15:8];
    end
    // A write after a load refills the buffer while the shifter runs
    empty_d = empty_q;
    if (!ctrl_q[CTRL_TXEN]) begin
      empty_d = 1'b1;
    end else if (wr_hold) begin
      empty_d = 1'b0;
    end else if (tx.load) begin
      empty_d = 1'b1;
    end
    // Writing zero clears a flag; a new event in the same cycle wins
    full_d  = full_q & !(wr_stat && !wdata_q[ST_FULL]);
    ovr_d   = ovr_q & !(wr_stat && !wdata_q[ST_OVR]);
    frm_d   = frm_q & !(wr_stat && !wdata_q[ST_FRM]);
    par_d   = par_q & !(wr_stat && !wdata_q[ST_PAR]);
    mpb_d   = mpb_q;
    rxbuf_d = rxbuf_q;
    if (rx_done) begin
      if (full_q) begin
        ovr_d = 1'b1;
      end else begin
        full_d  = 1'b1;
        rxbuf_d = rdat;
        frm_d   = frm_d | !rxd_s_q;
        par_d   = par_d | (fmt_q[FMT_PE] && !fmt_q[FMT_MP]
                  && (^rdat ^ rext ^ fmt_q[FMT_ODD]));
        mpb_d   = fmt_q[FMT_MP] && rext;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      hold_q  <= HOLD_RST;
      fmt_q   <= FMT_RST;
      ctrl_q  <= CTRL_RST;
      rxbuf_q <= RXD_RST;
      empty_q <= 1'b1;
      full_q  <= 1'b0;
      ovr_q   <= 1'b0;
      frm_q   <= 1'b0;
      par_q   <= 1'b0;
      mpb_q   <= 1'b0;
    end else begin
      hold_q  <= hold_d;
      fmt_q   <= fmt_d;
      ctrl_q  <= ctrl_d;
      rxbuf_q <= rxbuf_d;
      empty_q <= empty_d;
      full_q  <= full_d;
      ovr_q   <= ovr_d;
      frm_q   <= frm_d;
      par_q   <= par_d;
      mpb_q   <= mpb_d;
    end
  end

  // ==========================================================================
  // Transmit shifter
  scf_tx_shifter u_shifter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .link    (tx.shf)
  );

endmodule : scf_top

`default_nettype wire

// *** tb/scf_properties.sv ***
// Port checker for the serial format block.
// Assumes binding into scf_top, one clock domain.
`default_nettype none

module scf_properties import scf_pkg::*; #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [7:0]  awaddr,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // Pins
  input wire logic        standby,
  input wire logic        txd,
  input wire logic        sck,
  input wire logic        rxd
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Shadow registers, updated at the write answer
  logic [7:0] hold_q, hold_d, fmt_q, fmt_d, wa_q, wa_d, wd_q, wd_d;
  logic       ws_q, ws_d;

  always_comb begin
    wa_d = (awvalid && awready) ? awaddr : wa_q;
    wd_d = (wvalid && wready) ? wdata[7:0] : wd_q;
    ws_d = (wvalid && wready) ? wstrb[0] : ws_q;
    hold_d = hold_q;
    fmt_d = fmt_q;
    if (standby) begin
      hold_d = HOLD_RST;
      fmt_d = FMT_RST;
    end else if (bvalid && bready && ws_q) begin
      if (wa_q[7:2] == ADDR_HOLD[7:2]) hold_d = wd_q;
      if (wa_q[7:2] == ADDR_FMT[7:2]) fmt_d = wd_q;
    end
  end

  always_ff @(posedge aclk) begin
    wa_q <= wa_d;
    wd_q <= wd_d;
    ws_q <= ws_d;
    hold_q <= aresetn ? hold_d : HOLD_RST;
    fmt_q <= aresetn ? fmt_d : FMT_RST;
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken; awvalid && awready && wvalid && wready; endsequence
  sequence rd_taken; arvalid && arready; endsequence
  sequence low_run; !txd [*8]; endsequence

  // Write lands one edge after both slots close, answer on that same edge
  a_write_answer: assert property (wr_taken |=> ##1 bvalid) else $error("no write answer");
  a_read_answer: assert property (rd_taken |=> rvalid) else $error("no read answer");
  a_resp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_read_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_hold_value: assert property (rd_taken ##0 araddr[7:2] == ADDR_HOLD[7:2] |=>
    rdata == {24'h0, hold_q}) else $error("holding value wrong");
  a_fmt_value: assert property (rd_taken ##0 araddr[7:2] == ADDR_FMT[7:2] |=>
    rdata == {24'h0, fmt_q}) else $error("format value wrong");
  a_unmapped_read: assert property (rd_taken ##0 araddr[7:2] > 6'h04 |=>
    rresp == RESP_DECERR && rdata == 32'h0) else $error("unmapped read answered");
  a_start_width: assert property ($fell(txd) |-> low_run) else $error("start bit short");
  a_standby_idle: assert property (standby |=> txd && sck) else $error("line busy in standby");
endmodule : scf_properties

bind scf_top scf_properties #(.DIV_W(DIV_W)) u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
  .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .rresp(rresp), .standby(standby), .txd(txd), .sck(sck), .rxd(rxd));

`default_nettype wire

// *** tb/scf_serial_peer.sv ***
// Far-side receiver: decodes transmitted frames, idles its own line.
// Assumes 16 clocks per bit (no prescale, divisor zero).
`default_nettype none

module scf_serial_peer (
  // Clock
  input wire logic         aclk,
  // Serial pins
  input wire logic         txd,
  output logic             rxd,
  // Frame report
  input wire logic [3:0]   nbits,
  output logic             done,
  output logic [11:0]      bits
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Sample mid bit; no wait after the last so a back-to-back start is seen
  initial begin
    rxd = 1'b1;
    done = 1'b0;
    bits = '0;
    forever begin
      @(negedge txd);
      bits = '0;
      for (int i = 0; i < nbits; i++) begin
        repeat (i ? 16 : 8) @(posedge aclk);
        bits[i] = txd;
      end
      done <= 1'b1;
      @(posedge aclk);
      done <= 1'b0;
    end
  end
endmodule : scf_serial_peer

`default_nettype wire

// *** tb/serial_format_and_tx_buffer_test.sv ***
// Self-checking bench: register access and transmitted frames.
// Assumes scf_top with the serial peer on its pins.
`default_nettype none

module serial_format_and_tx_buffer_test import scf_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, standby, txd, sck, rxd, done;
  logic [7:0]  awaddr, araddr, f;
  logic [7:0]  fmts [5] = '{8'h00, 8'h78, 8'h20, 8'h34, 8'h48};
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb, nbits;
  logic [1:0]  bresp, rresp;
  logic [11:0] bits;
  logic [33:0] exp_bus[$];
  logic [15:0] exp_fr[$];
  int          mismatches, n_compared, cycles;
  integer      seed = 32'h8b4319d3;

  scf_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .standby(standby), .txd(txd), .sck(sck), .rxd(rxd));
  scf_serial_peer peer (.aclk(aclk), .txd(txd), .rxd(rxd), .nbits(nbits),
    .done(done), .bits(bits));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ==========================================================================
  // Checks and bus tasks
  task automatic check(string what, logic [33:0] seen, logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    exp_bus.push_back({r, 32'h0});
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [33:0] e);
    exp_bus.push_back(e);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // Expected frame, start bit first; multiprocessor bit sent as 0
  function automatic logic [15:0] frame(logic [7:0] c, logic [7:0] d);
    logic [11:0] b;
    int n;
    b = '0;
    n = 1;
    for (int i = 0; i < (c[6] ? 7 : 8); i++) begin
      b[n] = d[i];
      n++;
    end
    if (c[2] || c[5]) begin
      b[n] = c[2] ? 1'b0 : ^(d & {~c[6], 7'h7f}) ^ c[4];
      n++;
    end
    b[n] = 1'b1;
    b[n + 1] = c[3];
    return {4'(n + 1 + c[3]), b};
  endfunction : frame

  // ==========================================================================
  // Result watcher and hang limit
  always @(posedge aclk) begin
    cycles++;
    if ((rvalid && rready) || (bvalid && bready))
      check("bus", rvalid ? {rresp, rdata} : {bresp, 32'h0}, exp_bus.pop_front());
    if (done) check("frame", {nbits, bits}, exp_fr.pop_front());
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, standby} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    nbits = 4'd10;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_HOLD, {RESP_OKAY, 24'h0, HOLD_RST});
    rd(ADDR_FMT, {RESP_OKAY, 32'h0});
    rd(8'h14, {RESP_DECERR, 32'h0});
    wr(8'h18, 32'h0, RESP_DECERR);
    repeat (6) begin
      v = $random(seed);
      wr(ADDR_FMT, v, RESP_OKAY);
      rd(ADDR_FMT, {RESP_OKAY, 24'h0, v[7:0]});
      wr(ADDR_HOLD, ~v, RESP_OKAY);
      rd(ADDR_HOLD, {RESP_OKAY, 24'h0, ~v[7:0]});
    end
    // Standby resets the holding and format registers
    @(posedge aclk);
    standby <= 1'b1;
    @(posedge aclk);
    standby <= 1'b0;
    rd(ADDR_HOLD, {RESP_OKAY, 24'h0, HOLD_RST});
    rd(ADDR_FMT, {RESP_OKAY, 32'h0});
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    foreach (fmts[i]) begin
      f = fmts[i];
      v = $random(seed);
      exp_fr.push_back(frame(f, v[7:0]));
      exp_fr.push_back(frame(f, v[15:8]));
      nbits <= exp_fr[0][15:12];
      wr(ADDR_FMT, {24'h0, f}, RESP_OKAY);
      wr(ADDR_HOLD, v, RESP_OKAY);
      // Refill while the first character is still shifting
      @(negedge txd);
      wr(ADDR_HOLD, v >> 8, RESP_OKAY);
      while (exp_fr.size() != 0) @(posedge aclk);
    end
    print_verdict();
  end
endmodule : serial_format_and_tx_buffer_test

`default_nettype wire
